// ===== design/txdrv_params.svh
`ifndef TXDRV_PARAMS_SVH
`define TXDRV_PARAMS_SVH
// Operation
// RULE1: Bit 7 of driver mode inverts the second driver pin.
// RULE2: Bit 6 of driver mode inverts the first driver pin.
// RULE3: Bit 3 of driver mode enables both driver pins together.
// RULE4: Bits 2..0 select open-drain, push-pull, high impedance, fixed high or low.
// RULE5: Software never writes clock mode codes 011b or 110b.
// RULE6: Bits 7..6 reduce carrier level by 100, 250, 500 or 1000 mV.
// RULE7: Maximum carrier bit forces full amplitude, ignoring the reduction field.
// RULE8: Bits 4..0 of amplitude set the residual carrier percentage.
// RULE9: Bits 7..4 of control give overshoot modulation length in carrier clocks.
// RULE10: Control bit 2 inverts the selected modulation signal.
// RULE11: Source select: 00 none, 01 internal envelope, 10 external input.
// RULE12: Reserved source code 11 behaves as no modulation.

// ----------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------
`define DRIVER_MODE_INDEX 6'h28
`define TRANSMIT_AMPLITUDE_INDEX 6'h29
`define TRANSMIT_CONTROL_INDEX 6'h2A
`define DRIVER_MODE_ADDR {`DRIVER_MODE_INDEX, 2'b00}
`define TRANSMIT_AMPLITUDE_ADDR {`TRANSMIT_AMPLITUDE_INDEX, 2'b00}
`define TRANSMIT_CONTROL_ADDR {`TRANSMIT_CONTROL_INDEX, 2'b00}

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define DRIVER_MODE_RESET 8'h00
`define TRANSMIT_AMPLITUDE_RESET 8'h00
`define TRANSMIT_CONTROL_RESET 8'h00
`define DRIVER_MODE_MASK 8'hCF
`define TRANSMIT_AMPLITUDE_MASK 8'hDF
`define TRANSMIT_CONTROL_MASK 8'hFF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SECOND_PIN_INVERT_BIT 7
`define FIRST_PIN_INVERT_BIT 6
`define DRIVER_OUTPUT_ENABLE_BIT 3
`define MAX_CARRIER_BIT 3
`define MODULATION_INVERT_BIT 2
`endif

// ===== design/txdrv_pkg.sv
package txdrv_pkg;
    typedef enum logic [2:0] {
        MODE_OPEN_DRAIN = 3'h0,
        MODE_PUSH_PULL = 3'h1,
        MODE_HIGH_Z = 3'h2,
        MODE_BAD_3 = 3'h3,
        MODE_FIXED_HIGH = 3'h4,
        MODE_FIXED_LOW = 3'h5,
        MODE_BAD_6 = 3'h6,
        MODE_IDLE = 3'h7
    } clock_mode_t;
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_ENVELOPE = 2'h1,
        SRC_EXTERNAL = 2'h2,
        SRC_RESERVED = 2'h3
    } mod_source_t;
    typedef enum logic [1:0] {
        DROP_100MV = 2'h0,
        DROP_250MV = 2'h1,
        DROP_500MV = 2'h2,
        DROP_1000MV = 2'h3
    } level_drop_t;
endpackage

// ===== design/overshoot_timer.sv
`timescale 1ns/100ps
// ----------------------------------------
// Extends modulation by a count of carrier clocks
// ----------------------------------------
module overshoot_timer #(
    parameter int LEN_W = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic carrier_tick,
    input wire logic mod_in,
    input wire logic [LEN_W-1:0] length,
    output logic mod_out
);
    logic mod_prev_reg;
    logic [LEN_W-1:0] count_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            mod_prev_reg <= 1'b0;
        else
            mod_prev_reg <= mod_in;
    end

    // Falling edge of modulation loads the extension count
    always_ff @(posedge clk)
    begin
        if (!nrst)
            count_reg <= '0;
        else if (mod_prev_reg && !mod_in)
            count_reg <= length; // RULE9
        else if (carrier_tick && count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    // Falling cycle is covered before the count loads, so no gap appears
    assign mod_out = mod_in || (count_reg != '0) || (mod_prev_reg && length != '0);

    property p_ext_load;
        @(posedge clk) disable iff (!nrst)
        (mod_prev_reg && !mod_in && length != '0) |-> mod_out ##1 mod_out;
    endproperty
    a_ext_load: assert property (p_ext_load) else $error("overshoot not extended"); // RULE9

    property p_ext_zero;
        @(posedge clk) disable iff (!nrst)
        (mod_prev_reg && !mod_in && length == '0) |=> (mod_out == mod_in);
    endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("zero length extended modulation"); // RULE9
endmodule

// ===== design/txdrv_config.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "txdrv_params.svh"
module txdrv_config (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic carrier_in,
    input wire logic carrier_tick,
    input wire logic internal_transmit_envelope,
    input wire logic external_signal_input,
    output logic first_driver_pin_o,
    output logic first_driver_pin_oe_n,
    output logic second_driver_pin_o,
    output logic second_driver_pin_oe_n,
    output logic carrier_max,
    output txdrv_pkg::level_drop_t carrier_level_reduction,
    output logic [4:0] residual_carrier,
    output logic modulation_active
);
    import txdrv_pkg::*;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] driver_mode_reg;
    logic [7:0] transmit_amplitude_reg;
    logic [7:0] transmit_control_reg;

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wlane_reg;
    logic do_write;
    logic wr_hit;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `DRIVER_MODE_ADDR) || (a == `TRANSMIT_AMPLITUDE_ADDR)
            || (a == `TRANSMIT_CONTROL_ADDR);
    endfunction

    function automatic logic [7:0] aligned(input logic [7:0] a);
        aligned = {a[7:2], 2'b00};
    endfunction

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = addr_hit(awaddr_reg);

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
    end

    // Each register is one aligned word held in byte lane 0
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wlane_reg <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
        end
        else if (do_write)
            w_held_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            driver_mode_reg <= `DRIVER_MODE_RESET;
            transmit_amplitude_reg <= `TRANSMIT_AMPLITUDE_RESET;
            transmit_control_reg <= `TRANSMIT_CONTROL_RESET;
        end
        else if (do_write && wlane_reg)
        begin
            case (awaddr_reg)
                `DRIVER_MODE_ADDR: driver_mode_reg <= wdata_reg & `DRIVER_MODE_MASK;
                `TRANSMIT_AMPLITUDE_ADDR: transmit_amplitude_reg <= wdata_reg & `TRANSMIT_AMPLITUDE_MASK;
                `TRANSMIT_CONTROL_ADDR: transmit_control_reg <= wdata_reg & `TRANSMIT_CONTROL_MASK;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    logic [7:0] rd_byte;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        case (s_axi_araddr)
            `DRIVER_MODE_ADDR: rd_byte = driver_mode_reg;
            `TRANSMIT_AMPLITUDE_ADDR: rd_byte = transmit_amplitude_reg;
            `TRANSMIT_CONTROL_ADDR: rd_byte = transmit_control_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= addr_hit(s_axi_araddr) ? 2'h0 : 2'h2;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Modulation source and overshoot
    // ----------------------------------------
    mod_source_t src;
    logic mod_sel;
    logic mod_raw;
    logic mod_ext;

    assign src = mod_source_t'(transmit_control_reg[1:0]);

    always_comb
    begin
        case (src)
            SRC_NONE: mod_sel = 1'b0; // RULE11
            SRC_ENVELOPE: mod_sel = internal_transmit_envelope; // RULE11
            SRC_EXTERNAL: mod_sel = external_signal_input; // RULE11
            default: mod_sel = 1'b0; // RULE12
        endcase
    end

    // Inversion only applies when a real source is chosen
    assign mod_raw = (src == SRC_ENVELOPE || src == SRC_EXTERNAL)
        ? (mod_sel ^ transmit_control_reg[`MODULATION_INVERT_BIT]) : 1'b0; // RULE10 RULE12

    overshoot_timer #(
        .LEN_W(4)
    ) u_overshoot (
        .clk(clk),
        .nrst(nrst),
        .carrier_tick(carrier_tick),
        .mod_in(mod_raw),
        .length(transmit_control_reg[7:4]),
        .mod_out(mod_ext)
    );

    // ----------------------------------------
    // Driver outputs
    // ----------------------------------------
    clock_mode_t cmode;
    logic en;
    logic drv1;
    logic drv2;
    logic o_lvl;
    logic oe_act;

    assign cmode = clock_mode_t'(driver_mode_reg[2:0]);
    assign en = driver_mode_reg[`DRIVER_OUTPUT_ENABLE_BIT];

    // Unsupported codes fall to high impedance; software keeps them out
    always_comb
    begin
        o_lvl = carrier_in;
        oe_act = 1'b0;
        case (cmode)
            MODE_OPEN_DRAIN:
            begin
                o_lvl = 1'b0;
                oe_act = !carrier_in; // RULE4
            end
            MODE_PUSH_PULL:
            begin
                o_lvl = carrier_in;
                oe_act = 1'b1; // RULE4
            end
            MODE_HIGH_Z: oe_act = 1'b0; // RULE4
            MODE_FIXED_HIGH:
            begin
                o_lvl = 1'b1;
                oe_act = 1'b1; // RULE4
            end
            MODE_FIXED_LOW:
            begin
                o_lvl = 1'b0;
                oe_act = 1'b1; // RULE4
            end
            default: oe_act = 1'b0; // RULE5
        endcase
    end

    assign drv1 = o_lvl ^ driver_mode_reg[`FIRST_PIN_INVERT_BIT]; // RULE2
    assign drv2 = o_lvl ^ driver_mode_reg[`SECOND_PIN_INVERT_BIT]; // RULE1

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            first_driver_pin_o <= 1'b0;
            second_driver_pin_o <= 1'b0;
            first_driver_pin_oe_n <= 1'b1;
            second_driver_pin_oe_n <= 1'b1;
        end
        else
        begin
            first_driver_pin_o <= drv1;
            second_driver_pin_o <= drv2;
            first_driver_pin_oe_n <= !(en && oe_act); // RULE3
            second_driver_pin_oe_n <= !(en && oe_act); // RULE3
        end
    end

    // ----------------------------------------
    // Amplitude controls
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            carrier_max <= 1'b0;
            carrier_level_reduction <= DROP_100MV;
            residual_carrier <= 5'h00;
            modulation_active <= 1'b0;
        end
        else
        begin
            carrier_max <= transmit_control_reg[`MAX_CARRIER_BIT]; // RULE7
            // Reduction forced to the smallest drop while maximum is set
            carrier_level_reduction <= transmit_control_reg[`MAX_CARRIER_BIT]
                ? DROP_100MV : level_drop_t'(transmit_amplitude_reg[7:6]); // RULE6 RULE7
            residual_carrier <= transmit_amplitude_reg[4:0]; // RULE8
            modulation_active <= mod_ext;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_enable_both;
        @(posedge clk) disable iff (!nrst)
        !driver_mode_reg[3] |=> (first_driver_pin_oe_n && second_driver_pin_oe_n);
    endproperty
    a_enable_both: assert property (p_enable_both) else $error("pin driven while disabled"); // RULE3

    property p_same_enable;
        @(posedge clk) disable iff (!nrst)
        first_driver_pin_oe_n == second_driver_pin_oe_n;
    endproperty
    a_same_enable: assert property (p_same_enable) else $error("pin enables differ"); // RULE3

    property p_inv_pins;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (first_driver_pin_o ^ second_driver_pin_o) == ($past(driver_mode_reg[7]) ^ $past(driver_mode_reg[6]));
    endproperty
    a_inv_pins: assert property (p_inv_pins) else $error("pin inversion wrong"); // RULE1

    property p_inv_first;
        @(posedge clk) disable iff (!nrst)
        ($past(cmode) == MODE_FIXED_HIGH) |-> first_driver_pin_o == !$past(driver_mode_reg[6]);
    endproperty
    a_inv_first: assert property (p_inv_first) else $error("first pin inversion wrong"); // RULE2

    property p_push_pull;
        @(posedge clk) disable iff (!nrst)
        (cmode == MODE_PUSH_PULL && en) |=> !first_driver_pin_oe_n;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull not driven"); // RULE4

    property p_max;
        @(posedge clk) disable iff (!nrst)
        transmit_control_reg[3] |=> (carrier_max && carrier_level_reduction == DROP_100MV);
    endproperty
    a_max: assert property (p_max) else $error("maximum carrier not applied"); // RULE7

    property p_level;
        @(posedge clk) disable iff (!nrst)
        !transmit_control_reg[3] |=> carrier_level_reduction == $past(transmit_amplitude_reg[7:6]);
    endproperty
    a_level: assert property (p_level) else $error("level reduction wrong"); // RULE6

    property p_resid;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> residual_carrier == $past(transmit_amplitude_reg[4:0]);
    endproperty
    a_resid: assert property (p_resid) else $error("residual carrier wrong"); // RULE8

    property p_no_mod;
        @(posedge clk) disable iff (!nrst)
        (src == SRC_NONE || src == SRC_RESERVED) |-> !mod_raw;
    endproperty
    a_no_mod: assert property (p_no_mod) else $error("modulation without source"); // RULE11 RULE12

    property p_invert;
        @(posedge clk) disable iff (!nrst)
        (src == SRC_ENVELOPE) |-> mod_raw == (internal_transmit_envelope ^ transmit_control_reg[2]);
    endproperty
    a_invert: assert property (p_invert) else $error("modulation inversion wrong"); // RULE10
endmodule

// ===== sim/antenna_net.sv
`timescale 1ns/100ps
// ----------------------------------------
// Matching network seen from the two driver pins
// ----------------------------------------
module antenna_net #(
    parameter logic PULL = 1'b0
) (
    input wire logic first_o,
    input wire logic first_oe_n,
    input wire logic second_o,
    input wire logic second_oe_n,
    output logic first_level,
    output logic second_level
);
    // A released pin is pulled through the coil to a fixed level
    assign first_level = first_oe_n ? PULL : first_o;
    assign second_level = second_oe_n ? PULL : second_o;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    import txdrv_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic carrier_in = 1'b1, tick = 1'b0, env = 1'b0, ext = 1'b0;
    logic f_o, f_oe_n, s_o, s_oe_n, cmax, f_lvl, s_lvl, mod_act;
    level_drop_t drop;
    logic [4:0] resid;
    logic [1:0] resp;
    logic [31:0] rd;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] row_addr [4] = '{8'hA0, 8'hA4, 8'hA8, 8'hA0};
    logic [31:0] row_wd [4] = '{32'hFFFF_FFFF, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000};
    logic [31:0] row_rd [4] = '{32'h0000_00CF, 32'h0000_00DF, 32'h0000_00FF, 32'h0000_0000};
    logic [7:0] pin_mode [6] = '{8'h09, 8'h01, 8'h0A, 8'h08, 8'h0C, 8'h0D};
    logic [3:0] pin_exp [6] = '{4'b1010, 4'b1111, 4'b1111, 4'b0101, 4'b1010, 4'b0000};
    logic [7:0] src_val [8] = '{8'h01, 8'h02, 8'h12, 8'h06, 8'h03, 8'h07, 8'h00, 8'h04};
    logic src_exp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    always #20 clk = ~clk;

    txdrv_config DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .carrier_in(carrier_in),
        .carrier_tick(tick), .internal_transmit_envelope(env), .external_signal_input(ext),
        .first_driver_pin_o(f_o), .first_driver_pin_oe_n(f_oe_n), .second_driver_pin_o(s_o),
        .second_driver_pin_oe_n(s_oe_n), .carrier_max(cmax), .carrier_level_reduction(drop),
        .residual_carrier(resid), .modulation_active(mod_act));

    antenna_net #(.PULL(1'b0)) antenna (.first_o(f_o), .first_oe_n(f_oe_n), .second_o(s_o),
        .second_oe_n(s_oe_n), .first_level(f_lvl), .second_level(s_lvl));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Handshakes are judged at the falling edge, where they hold until the rising edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        while (!b_t)
        begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            resp = bresp;
            @(posedge clk);
            if (aw_t)
                awvalid <= 1'b0;
            if (w_t)
                wvalid <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_t)
        begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_t)
                arvalid <= 1'b0;
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // ----------------------------------------
        // Register rows: write, read back through the writable mask
        // ----------------------------------------
        for (int i = 0; i < 4; i++)
        begin
            axi_write(row_addr[i], row_wd[i]);
            axi_read(row_addr[i]);
            chk(rd, row_rd[i]);
            chk({30'h0, resp}, 32'h0);
        end
        $display("test registers done");
        // ----------------------------------------
        // Unmapped address and second reset
        // ----------------------------------------
        axi_write(8'h30, 32'h0000_00FF);
        chk({30'h0, resp}, 32'h2);
        axi_read(8'h30);
        chk({30'h0, resp}, 32'h2);
        chk(rd, 32'h0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            axi_read(8'hA0 + 8'(4 * i));
            chk(rd, 32'h0);
        end
        chk({30'h0, f_oe_n, s_oe_n}, 32'h3);
        $display("test reset done");
        // ----------------------------------------
        // Carrier amplitude
        // ----------------------------------------
        axi_write(8'hA4, 32'h0000_008A);
        settle(2);
        chk({30'h0, drop}, 32'h2);
        chk({27'h0, resid}, 32'h0A);
        chk({31'h0, cmax}, 32'h0);
        axi_write(8'hA8, 32'h0000_0008);
        settle(2);
        chk({31'h0, cmax}, 32'h1);
        chk({30'h0, drop}, 32'h0);
        $display("test amplitude done");
        // ----------------------------------------
        // Driver pins: {first_o, first_oe_n, second_o, second_oe_n}
        // ----------------------------------------
        for (int i = 0; i < 6; i++)
        begin
            axi_write(8'hA0, {24'h0, pin_mode[i]});
            settle(2);
            chk({28'h0, f_o, f_oe_n, s_o, s_oe_n}, {28'h0, pin_exp[i]});
        end
        chk({30'h0, f_lvl, s_lvl}, 32'h0);
        axi_write(8'hA0, 32'h0000_0049);
        settle(2);
        chk({30'h0, f_o, s_o}, 32'h1);
        axi_write(8'hA0, 32'h0000_0089);
        settle(2);
        chk({30'h0, f_o, s_o}, 32'h2);
        axi_write(8'hA0, 32'h0000_00C9);
        settle(2);
        chk({30'h0, f_o, s_o}, 32'h0);
        // Open drain pulls the pin low while the carrier is low
        @(posedge clk);
        carrier_in <= 1'b0;
        axi_write(8'hA0, 32'h0000_0008);
        settle(2);
        chk({28'h0, f_o, f_oe_n, s_o, s_oe_n}, 32'h0);
        @(posedge clk);
        carrier_in <= 1'b1;
        $display("test pins done");
        // ----------------------------------------
        // Modulation source, inversion, reserved code
        // ----------------------------------------
        @(posedge clk);
        env <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            if (i == 2)
                ext <= 1'b1;
            axi_write(8'hA8, {24'h0, src_val[i]});
            settle(3);
            chk({31'h0, mod_act}, {31'h0, src_exp[i]});
        end
        $display("test modulation done");
        // ----------------------------------------
        // Overshoot: two carrier clocks after the envelope falls
        // ----------------------------------------
        axi_write(8'hA8, 32'h0000_0021);
        settle(3);
        chk({31'h0, mod_act}, 32'h1);
        @(posedge clk);
        env <= 1'b0;
        settle(4);
        chk({31'h0, mod_act}, 32'h1);
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        settle(2);
        chk({31'h0, mod_act}, 32'h1);
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        settle(3);
        chk({31'h0, mod_act}, 32'h0);
        $display("test overshoot done");
        print_verdict();
    end
endmodule
